// File: hw/asp_top.sv
// Async serial port with infrared coding, FIFOs and APB registers
`timescale 1ns/1ps
module asp_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line
  input  wire logic        serial_in,
  output logic             serial_out,
  // Interrupt request
  output logic             irq
);
  // Transmit parity bit for the configured length
  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] wl,
                                   input logic even);
    par_bit = (^(d & (8'hff >> (2'h3 - wl)))) ^ ~even;
  endfunction

  // FIFO level that a threshold code stands for
  function automatic logic [4:0] level_of(input logic [2:0] sel);
    case (sel)
      3'h0:    level_of = 5'h02;
      3'h1:    level_of = 5'h04;
      3'h3:    level_of = 5'h0c;
      3'h4:    level_of = 5'h0e;
      default: level_of = 5'h08;
    endcase
  endfunction

  logic [15:0] ibrd_q;
  logic [5:0]  fbrd_q;
  logic [29:0] cfg_q;
  logic [9:0]  ctl_q;
  logic [5:0]  ifls_q;
  logic [10:0] im_q, ris_q;
  logic [3:0]  rsr_q;
  logic        rx_seen_q;
  logic        tick, lp_tick;
  logic [7:0]  tx_rdata;
  logic [11:0] rx_rdata;
  logic        tx_empty, tx_full, rx_empty, rx_full;
  logic [4:0]  tx_count, rx_count;
  asp_pkg::asp_state_e tx_st_q, rx_st_q;
  logic [3:0]  tx_sub_q, rx_sub_q, sir_hold_q;
  logic [2:0]  tx_bits_q, rx_bits_q;
  logic [7:0]  tx_sh_q, rx_sh_q;
  logic        tx_bit_q, tx_par_q, tx_stop2_q;
  logic [1:0]  lp_cnt_q;
  logic        in_s1_q, in_s2_q, rx_prev_q, rx_pbit_q, oe_pend_q;
  logic [9:0]  rt_cnt_q;

  // Bus decode
  wire setup     = psel && !penable;
  wire acc       = psel && penable && pready;
  wire wr        = acc && pwrite;
  wire sel_data  = paddr == asp_pkg::DATA_OFF;
  wire sel_rsr   = paddr == asp_pkg::RSR_OFF;
  wire sel_flag  = paddr == asp_pkg::FLAG_OFF;
  wire sel_ibrd  = paddr == asp_pkg::IBRD_OFF;
  wire sel_fbrd  = paddr == asp_pkg::FBRD_OFF;
  wire sel_lcrh  = paddr == asp_pkg::LCRH_OFF;
  wire sel_ctl   = paddr == asp_pkg::CTL_OFF;
  wire sel_ifls  = paddr == asp_pkg::IFLS_OFF;
  wire sel_im    = paddr == asp_pkg::IM_OFF;
  wire sel_ris   = paddr == asp_pkg::RIS_OFF;
  wire sel_mis   = paddr == asp_pkg::MIS_OFF;
  wire sel_icr   = paddr == asp_pkg::ICR_OFF;
  wire hit = sel_data | sel_rsr | sel_flag | sel_ibrd | sel_fbrd | sel_lcrh
           | sel_ctl | sel_ifls | sel_im | sel_ris | sel_mis | sel_icr;

  // Live settings from the shadow word and control
  wire [15:0] cfg_int  = cfg_q[29:14];
  wire [5:0]  cfg_frac = cfg_q[13:8];
  wire [7:0]  lcrh     = cfg_q[7:0];
  wire [1:0]  wlen     = lcrh[asp_pkg::LC_WLEN +: 2];
  wire [2:0]  last_idx = {1'b0, wlen} + 3'h4;
  wire        pen      = lcrh[asp_pkg::LC_PEN];
  wire        fifo_on  = lcrh[asp_pkg::LC_FEN];
  wire        port_on  = ctl_q[asp_pkg::CT_PORT];
  wire        sir_on   = ctl_q[asp_pkg::CT_SIR];
  wire        loop_on  = ctl_q[asp_pkg::CT_LOOP];
  wire        busy     = !tx_empty || tx_st_q != asp_pkg::ST_IDLE;

  // Oversample tick and the slow low-power infrared tick
  asp_baud u_baud (
    .pclk     (pclk),
    .presetn  (presetn),
    .div_int  (cfg_int),
    .div_frac (cfg_frac),
    .tick     (tick)
  );
  asp_baud u_lp (
    .pclk     (pclk),
    .presetn  (presetn),
    .div_int  (asp_pkg::LP_DIV),
    .div_frac (6'h00),
    .tick     (lp_tick)
  );

  // Transmit side: frame starts only from idle, so disable finishes it
  wire tx_load = tx_st_q == asp_pkg::ST_IDLE && port_on && !tx_empty
              && ctl_q[asp_pkg::CT_TXE];
  wire tx_push = wr && sel_data;
  wire tx_end  = tick && tx_sub_q == asp_pkg::LAST_TICK
              && tx_st_q != asp_pkg::ST_IDLE;
  wire sir_pulse = !tx_bit_q && tx_st_q != asp_pkg::ST_IDLE
                && (ctl_q[asp_pkg::CT_SIRLP] ? lp_cnt_q != asp_pkg::LP_PULSE
                                             : tx_sub_q < asp_pkg::SIR_TICKS);

  asp_fifo #(.W(8)) u_txf (
    .pclk    (pclk),
    .presetn (presetn),
    .deep    (fifo_on),
    .push    (tx_push),
    .wdata   (pwdata[7:0]),
    .pop     (tx_load),
    .rdata   (tx_rdata),
    .empty   (tx_empty),
    .full    (tx_full),
    .count   (tx_count)
  );

  // Transmit shifter, one bit per sixteen ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q    <= asp_pkg::ST_IDLE;
      tx_sub_q   <= 4'h0;
      tx_bits_q  <= 3'h0;
      tx_sh_q    <= 8'h00;
      tx_bit_q   <= 1'b1;
      tx_par_q   <= 1'b0;
      tx_stop2_q <= 1'b0;
    end else if (tx_load) begin
      tx_st_q  <= asp_pkg::ST_START;
      tx_sub_q <= 4'h0;
      tx_sh_q  <= tx_rdata;
      tx_bit_q <= 1'b0;
      tx_par_q <= par_bit(tx_rdata, wlen, lcrh[asp_pkg::LC_EVEN]);
    end else if (tick && tx_st_q != asp_pkg::ST_IDLE) begin
      tx_sub_q <= tx_sub_q + 4'h1;
      if (tx_end) begin
        case (tx_st_q)
          asp_pkg::ST_START: begin
            tx_st_q   <= asp_pkg::ST_DATA;
            tx_bits_q <= 3'h0;
            tx_bit_q  <= tx_sh_q[0];
            tx_sh_q   <= tx_sh_q >> 1;
          end
          asp_pkg::ST_DATA: begin
            if (tx_bits_q == last_idx) begin
              tx_st_q    <= pen ? asp_pkg::ST_PAR : asp_pkg::ST_STOP;
              tx_bit_q   <= pen ? tx_par_q : 1'b1;
              tx_stop2_q <= lcrh[asp_pkg::LC_STP2];
            end else begin
              tx_bits_q <= tx_bits_q + 3'h1;
              tx_bit_q  <= tx_sh_q[0];
              tx_sh_q   <= tx_sh_q >> 1;
            end
          end
          asp_pkg::ST_PAR: begin
            tx_st_q  <= asp_pkg::ST_STOP;
            tx_bit_q <= 1'b1;
          end
          default: begin
            tx_stop2_q <= 1'b0;
            if (!tx_stop2_q) begin
              tx_st_q <= asp_pkg::ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Line driver; low-power pulse counts slow ticks from each bit edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_cnt_q   <= 2'h0;
      serial_out <= 1'b1;
    end else begin
      if (tx_load || tx_end) begin
        lp_cnt_q <= 2'h0;
      end else if (lp_tick && lp_cnt_q != asp_pkg::LP_PULSE) begin
        lp_cnt_q <= lp_cnt_q + 2'h1;
      end
      serial_out <= sir_on ? sir_pulse : tx_bit_q;
    end
  end

  // Receive input: synchronise, loop back, then infrared decode
  wire rx_line = loop_on ? (sir_on ? ~serial_out : serial_out) : in_s2_q;
  wire rx_dec  = sir_on ? (rx_line && sir_hold_q == 4'h0) : rx_line;
  wire rx_allow = port_on && ctl_q[asp_pkg::CT_RXE] && !(sir_on && busy);
  wire rx_tick  = tick && rx_st_q != asp_pkg::ST_IDLE;
  wire rx_end   = rx_tick && rx_sub_q == asp_pkg::LAST_TICK;
  wire rx_push  = rx_end && rx_st_q == asp_pkg::ST_STOP;
  wire [7:0] rx_data = rx_sh_q >> (2'h3 - wlen);
  wire rx_fe = !rx_dec;
  wire rx_pe = pen && rx_pbit_q != par_bit(rx_data, wlen, lcrh[asp_pkg::LC_EVEN]);
  wire rx_be = rx_data == 8'h00 && !rx_dec && !(pen && rx_pbit_q);
  wire overrun = rx_push && rx_full;
  wire rx_pop  = acc && !pwrite && sel_data && rx_seen_q;
  wire [11:0] rx_wdata = {oe_pend_q, rx_be, rx_pe, rx_fe, rx_data};

  asp_fifo #(.W(12)) u_rxf (
    .pclk    (pclk),
    .presetn (presetn),
    .deep    (fifo_on),
    .push    (rx_push),
    .wdata   (rx_wdata),
    .pop     (rx_pop),
    .rdata   (rx_rdata),
    .empty   (rx_empty),
    .full    (rx_full),
    .count   (rx_count)
  );

  // Input synchroniser and infrared pulse stretcher
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1_q    <= 1'b1;
      in_s2_q    <= 1'b1;
      rx_prev_q  <= 1'b1;
      sir_hold_q <= 4'h0;
    end else begin
      in_s1_q   <= serial_in;
      in_s2_q   <= in_s1_q;
      rx_prev_q <= rx_dec;
      if (!rx_line) begin
        sir_hold_q <= asp_pkg::SIR_HOLD;
      end else if (tick && sir_hold_q != 4'h0) begin
        sir_hold_q <= sir_hold_q - 4'h1;
      end
    end
  end

  // Receive sampler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q   <= asp_pkg::ST_IDLE;
      rx_sub_q  <= 4'h0;
      rx_bits_q <= 3'h0;
      rx_sh_q   <= 8'h00;
      rx_pbit_q <= 1'b0;
      oe_pend_q <= 1'b0;
    end else begin
      if (rx_tick) begin
        rx_sub_q <= rx_sub_q + 4'h1;
      end
      case (rx_st_q)
        asp_pkg::ST_IDLE: begin
          if (rx_prev_q && !rx_dec && rx_allow) begin
            rx_st_q  <= asp_pkg::ST_START;
            rx_sub_q <= 4'h0;
          end
        end
        asp_pkg::ST_START: begin
          if (rx_tick && rx_sub_q == asp_pkg::MID_TICK) begin
            rx_sub_q  <= 4'h0;
            rx_bits_q <= 3'h0;
            rx_st_q   <= rx_dec ? asp_pkg::ST_IDLE : asp_pkg::ST_DATA;
          end
        end
        asp_pkg::ST_DATA: begin
          if (rx_end) begin
            rx_sh_q   <= {rx_dec, rx_sh_q[7:1]};
            rx_bits_q <= rx_bits_q + 3'h1;
            if (rx_bits_q == last_idx) begin
              rx_st_q <= pen ? asp_pkg::ST_PAR : asp_pkg::ST_STOP;
            end
          end
        end
        asp_pkg::ST_PAR: begin
          if (rx_end) begin
            rx_pbit_q <= rx_dec;
            rx_st_q   <= asp_pkg::ST_STOP;
          end
        end
        default: begin
          if (rx_end) begin
            rx_st_q <= asp_pkg::ST_IDLE;
          end
        end
      endcase
      if (overrun) begin
        oe_pend_q <= 1'b1;
      end else if (rx_push) begin
        oe_pend_q <= 1'b0;
      end
    end
  end

  // Timeout counts idle ticks while data waits, saturating at its limit
  wire rt_run = !rx_empty && rx_st_q == asp_pkg::ST_IDLE && !rx_pop;
  wire rt_set = tick && rt_run && rt_cnt_q == asp_pkg::RT_TICKS - 10'h001;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rt_cnt_q <= 10'h000;
    end else if (!rt_run) begin
      rt_cnt_q <= 10'h000;
    end else if (tick && rt_cnt_q != asp_pkg::RT_TICKS) begin
      rt_cnt_q <= rt_cnt_q + 10'h001;
    end
  end

  // Event sets win over clears from software or from draining the FIFO
  wire tx_lvl = fifo_on ? tx_count <= level_of(ifls_q[2:0]) : tx_empty;
  wire rx_lvl = fifo_on ? rx_count >= level_of(ifls_q[5:3]) : !rx_empty;
  wire [10:0] ev_set = {overrun, rx_push & rx_be, rx_push & rx_pe,
                        rx_push & rx_fe, rt_set, tx_lvl, rx_lvl, 4'h0};
  wire [10:0] ev_clr = (wr && sel_icr ? pwdata[10:0] : 11'h000)
                     | {4'h0, rx_pop && rx_count == 5'h01, 6'h00};
  wire [10:0] mis = ris_q & im_q;

  // Read data selection
  wire [7:0] flags = {tx_empty, rx_full, tx_full, rx_empty, busy, 3'h0};
  wire [31:0] rd_mux =
      sel_data ? {20'h00000, rx_rdata} :
      sel_rsr  ? {28'h0000000, rsr_q} :
      sel_flag ? {24'h000000, flags} :
      sel_ibrd ? {16'h0000, ibrd_q} :
      sel_fbrd ? {26'h0000000, fbrd_q} :
      sel_lcrh ? {24'h000000, lcrh} :
      sel_ctl  ? {22'h000000, ctl_q} :
      sel_ifls ? {26'h0000000, ifls_q} :
      sel_im   ? {21'h000000, im_q} :
      sel_ris  ? {21'h000000, ris_q} :
      sel_mis  ? {21'h000000, mis} : 32'h00000000;

  // Register writes; divisors reach the generator only with line control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ibrd_q <= 16'h0000;
      fbrd_q <= 6'h00;
      cfg_q  <= 30'h00000000;
      ctl_q  <= asp_pkg::CTL_RST;
      ifls_q <= asp_pkg::IFLS_RST;
      im_q   <= 11'h000;
      ris_q  <= 11'h000;
      rsr_q  <= 4'h0;
    end else begin
      if (wr && sel_ibrd) ibrd_q <= pwdata[15:0];
      if (wr && sel_fbrd) fbrd_q <= pwdata[5:0];
      if (wr && sel_lcrh) cfg_q <= {ibrd_q, fbrd_q, pwdata[7:0]};
      if (wr && sel_ctl) ctl_q <= pwdata[9:0];
      if (wr && sel_ifls) ifls_q <= pwdata[5:0];
      if (wr && sel_im) im_q <= pwdata[10:0];
      ris_q <= (ris_q & ~ev_clr) | ev_set;
      if (wr && sel_rsr) begin
        rsr_q <= {overrun, 3'h0};
      end else begin
        if (rx_pop) rsr_q[2:0] <= rx_rdata[10:8];
        if (overrun) rsr_q[3] <= 1'b1;
      end
    end
  end

  // Bus answer: data ready one cycle after setup, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata    <= 32'h00000000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      rx_seen_q <= 1'b0;
      irq       <= 1'b0;
    end else begin
      pready    <= setup;
      pslverr   <= setup && !hit;
      rx_seen_q <= setup && !rx_empty;
      if (setup && !pwrite) prdata <= rd_mux;
      irq <= |mis;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_busy;
    tx_push && !tx_full |=> busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not set after push");

  property p_cfg;
    wr && sel_ibrd |=> $stable(cfg_q);
  endproperty
  a_cfg: assert property (p_cfg) else $error("divisor applied early");

  property p_hold;
    !fifo_on && tx_full && tx_push |=> tx_count <= $past(tx_count);
  endproperty
  a_hold: assert property (p_hold) else $error("holding register took a second entry");

  property p_false;
    rx_st_q == asp_pkg::ST_START && tick && rx_sub_q == asp_pkg::MID_TICK && rx_dec
      |=> rx_st_q == asp_pkg::ST_IDLE ##1 !rx_push;
  endproperty
  a_false: assert property (p_false) else $error("false start not dropped");

  property p_fe;
    rx_push && !rx_dec && rx_empty |=> rx_rdata[8];
  endproperty
  a_fe: assert property (p_fe) else $error("framing flag missing");

  property p_clr;
    wr && sel_icr && pwdata[asp_pkg::EV_FE] && !ev_set[asp_pkg::EV_FE]
      |=> !ris_q[asp_pkg::EV_FE] && !mis[asp_pkg::EV_FE];
  endproperty
  a_clr: assert property (p_clr) else $error("clear did not drop event");

  property p_irq;
    im_q == 11'h000 |=> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("masked event raised request");

  property p_or;
    mis != 11'h000 |=> irq;
  endproperty
  a_or: assert property (p_or) else $error("event lost from request");

  property p_rt;
    rt_set |-> !rx_empty ##1 ris_q[asp_pkg::EV_RT];
  endproperty
  a_rt: assert property (p_rt) else $error("timeout without data");
endmodule

// File: hw/asp_pkg.sv
// Shared constants and types for the async serial port
package asp_pkg;
  // Register byte offsets
  localparam logic [11:0] DATA_OFF = 12'h000;
  localparam logic [11:0] RSR_OFF  = 12'h004;
  localparam logic [11:0] FLAG_OFF = 12'h018;
  localparam logic [11:0] IBRD_OFF = 12'h024;
  localparam logic [11:0] FBRD_OFF = 12'h028;
  localparam logic [11:0] LCRH_OFF = 12'h02c;
  localparam logic [11:0] CTL_OFF  = 12'h030;
  localparam logic [11:0] IFLS_OFF = 12'h034;
  localparam logic [11:0] IM_OFF   = 12'h038;
  localparam logic [11:0] RIS_OFF  = 12'h03c;
  localparam logic [11:0] MIS_OFF  = 12'h040;
  localparam logic [11:0] ICR_OFF  = 12'h044;
  // Line control fields
  localparam int LC_PEN  = 1;
  localparam int LC_EVEN = 2;
  localparam int LC_STP2 = 3;
  localparam int LC_FEN  = 4;
  localparam int LC_WLEN = 5;
  // Control fields and the control and level-select reset values
  localparam int CT_PORT = 0;
  localparam int CT_SIR  = 1;
  localparam int CT_SIRLP = 2;
  localparam int CT_LOOP = 7;
  localparam int CT_TXE  = 8;
  localparam int CT_RXE  = 9;
  localparam logic [9:0] CTL_RST  = 10'h300;
  localparam logic [5:0] IFLS_RST = 6'h12;
  // Event bit positions in raw, mask, masked and clear registers
  localparam int EV_RX = 4;
  localparam int EV_TX = 5;
  localparam int EV_RT = 6;
  localparam int EV_FE = 7;
  localparam int EV_PE = 8;
  localparam int EV_BE = 9;
  localparam int EV_OE = 10;
  // Flag register bit positions
  localparam int FL_BUSY = 3;
  // Timing counts in oversample ticks
  localparam logic [3:0] MID_TICK  = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hf;
  localparam logic [3:0] SIR_TICKS = 4'h3;
  localparam logic [3:0] SIR_HOLD  = 4'hc;
  localparam logic [9:0] RT_TICKS  = 10'h200;
  // Low-power infrared tick: nominal rate and divider from the 200 MHz clock
  localparam int CLK_HZ = 200_000_000;
  localparam int LP_HZ  = 1_843_200;
  localparam logic [15:0] LP_DIV = 16'(CLK_HZ / LP_HZ);
  localparam logic [1:0] LP_PULSE = 2'h3;
  // Serial state machine, Gray coded along the frame
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b011,
    ST_PAR   = 3'b010,
    ST_STOP  = 3'b110
  } asp_state_e;
endpackage

// File: hw/asp_baud.sv
// Fractional tick generator
`timescale 1ns/1ps
module asp_baud (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Divisor
  input  wire logic [15:0] div_int,
  input  wire logic [5:0]  div_frac,
  // Tick pulse
  output logic             tick
);
  logic [15:0] cnt_q;
  logic [5:0]  acc_q;
  logic        extra_q;

  // Carry of the sixty-fourths stretches the next period by one clock
  wire [6:0]  acc_sum = {1'b0, acc_q} + {1'b0, div_frac};
  wire [16:0] limit   = {1'b0, div_int} + {16'h0000, extra_q} - 17'h00001;
  wire        at_end  = {1'b0, cnt_q} >= limit;
  wire        run     = div_int != 16'h0000;

  // A zero divisor stops the ticks rather than running at clock rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= 16'h0000;
      acc_q   <= 6'h00;
      extra_q <= 1'b0;
      tick    <= 1'b0;
    end else if (!run) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (at_end) begin
      cnt_q   <= 16'h0000;
      acc_q   <= acc_sum[5:0];
      extra_q <= acc_sum[6];
      tick    <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule

// File: hw/asp_fifo.sv
// Sixteen-entry FIFO with a single-entry mode and registered head
`timescale 1ns/1ps
module asp_fifo #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Mode: full depth or one entry
  input  wire logic         deep,
  // Fill side
  input  wire logic         push,
  input  wire logic [W-1:0] wdata,
  // Drain side
  input  wire logic         pop,
  output logic      [W-1:0] rdata,
  // Status
  output logic              empty,
  output logic              full,
  output logic      [4:0]   count
);
  logic [W-1:0] mem [16];
  logic [3:0]   wptr_q;
  logic [3:0]   rptr_q;

  wire       do_push = push && !full;
  wire       do_pop  = pop && !empty;
  wire [3:0] rptr_d  = rptr_q + {3'h0, do_pop};

  // Single-entry mode behaves as a plain holding register
  assign empty = count == 5'h00;
  assign full  = deep ? (count == 5'h10) : (count != 5'h00);

  // Storage has no reset; only pointers, count and head carry state
  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wptr_q] <= wdata;
    end
  end

  // Head register bypasses a write into the slot about to be read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q <= 4'h0;
      rptr_q <= 4'h0;
      count  <= 5'h00;
      rdata  <= '0;
    end else begin
      wptr_q <= wptr_q + {3'h0, do_push};
      rptr_q <= rptr_d;
      count  <= count + {4'h0, do_push} - {4'h0, do_pop};
      rdata  <= (do_push && wptr_q == rptr_d) ? wdata : mem[rptr_d];
    end
  end
endmodule

// File: tb/asp_remote.sv
// Remote serial device model driving the port's receive line
`timescale 1ns/1ps
module asp_remote (
  // Clock
  input  wire logic       pclk,
  // Frame request
  input  wire logic       go,
  input  wire logic       glitch,
  input  wire logic [9:0] frame,
  // Line toward the port
  output logic            line
);
  logic [7:0] cnt = 8'h00;
  logic [9:0] sh  = 10'h3ff;
  // One bit per 16 clocks, LSB first; matches a divisor of one
  always_ff @(posedge pclk) begin
    if (go) begin
      sh  <= frame;
      cnt <= 8'ha0;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
      if (cnt[3:0] == 4'h1) sh <= {1'b1, sh[9:1]};
    end
  end
  // Idle high between frames; glitch makes a short false start
  assign line = glitch ? 1'b0 : ((cnt != 8'h00) ? sh[0] : 1'b1);
endmodule

// File: tb/async_serial_port_with_ir_tb_top.sv
// Register-level bench for the async serial port
`timescale 1ns/1ps
module async_serial_port_with_ir_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, go, glitch;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, serr, serial_in, serial_out, irq;
  logic [9:0]  frame, f1, f2;
  int          err_total, total_checks, hi, lo;
  asp_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in(serial_in),
    .serial_out(serial_out), .irq(irq));
  asp_remote u_rem (.pclk(pclk), .go(go), .glitch(glitch), .frame(frame),
    .line(serial_in));
  // Clock at 200 MHz
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic wrap_up();
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      wrap_up();
    end
  endtask
  // Catch one transmitted frame, sampling near the middle of each bit
  task automatic cap(output logic [9:0] f);
    int n;
    n = 0;
    while (serial_out !== 1'b0 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (serial_out !== 1'b0) begin
      err_total++;
      wrap_up();
    end
    repeat (8) @(posedge pclk);
    // Stop after the stop-bit sample so a back-to-back start is not missed
    for (int i = 0; i < 10; i++) begin
      f[i] = serial_out;
      if (i < 9) repeat (16) @(posedge pclk);
    end
  endtask
  // Width of the next high pulse on the line and of the low gap after it
  task automatic pulse(output int hi_n, output int lo_n);
    int n;
    n = 0;
    hi_n = 0;
    lo_n = 0;
    while (serial_out !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    while (serial_out === 1'b1 && hi_n < 300) begin
      @(posedge pclk);
      hi_n++;
    end
    while (serial_out !== 1'b1 && lo_n < 300) begin
      @(posedge pclk);
      lo_n++;
    end
    if (serial_out !== 1'b1) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic send(logic [9:0] f);
    @(posedge pclk);
    go <= 1'b1; frame <= f;
    @(posedge pclk);
    go <= 1'b0;
    repeat (170) @(posedge pclk);
  endtask
  // Main sequence
  initial begin
    err_total = 0; total_checks = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; go = 1'b0; glitch = 1'b0;
    frame = 10'h3ff;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, asp_pkg::IFLS_OFF, 32'h0);
    chk("level reset", rdat, 32'h12);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, asp_pkg::IFLS_OFF, 32'(i + (4 - i) * 8));
      apb(1'b0, asp_pkg::IFLS_OFF, 32'h0);
      chk("level select", rdat, 32'(i + (4 - i) * 8));
    end
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped error", {31'h0, serr}, 32'h1);
    // Divisor of one gives a 16-clock bit; fifo on, eight bits
    apb(1'b1, asp_pkg::IBRD_OFF, 32'h1);
    apb(1'b1, asp_pkg::FBRD_OFF, 32'h0);
    apb(1'b1, asp_pkg::LCRH_OFF, 32'h70);
    apb(1'b1, asp_pkg::CTL_OFF, 32'h301);
    apb(1'b1, asp_pkg::DATA_OFF, 32'ha5);
    // Catch the first frame from its start while the second byte queues
    fork
      cap(f1);
      begin
        apb(1'b1, asp_pkg::DATA_OFF, 32'h3c);
        apb(1'b0, asp_pkg::FLAG_OFF, 32'h0);
        chk("busy set", 32'(rdat[3]), 32'h1);
      end
    join
    cap(f2);
    chk("frame one", 32'(f1), 32'h34a);
    chk("frame two", 32'(f2), 32'h278);
    repeat (30) @(posedge pclk);
    apb(1'b0, asp_pkg::FLAG_OFF, 32'h0);
    chk("flags idle", rdat & 32'hf8, 32'h90);
    apb(1'b1, asp_pkg::CTL_OFF, 32'h381);
    apb(1'b1, asp_pkg::DATA_OFF, 32'h5a);
    repeat (200) @(posedge pclk);
    apb(1'b0, asp_pkg::DATA_OFF, 32'h0);
    chk("loopback data", rdat & 32'hfff, 32'h05a);
    apb(1'b1, asp_pkg::CTL_OFF, 32'h301);
    // False start, then a bad-stop frame and a clean one
    @(posedge pclk);
    glitch <= 1'b1;
    repeat (4) @(posedge pclk);
    glitch <= 1'b0;
    repeat (40) @(posedge pclk);
    apb(1'b0, asp_pkg::FLAG_OFF, 32'h0);
    chk("false start", 32'(rdat[4]), 32'h1);
    send(10'h102);
    send(10'h32c);
    repeat (600) @(posedge pclk);
    apb(1'b0, asp_pkg::RIS_OFF, 32'h0);
    chk("timeout raw", 32'(rdat[6]), 32'h1);
    chk("framing raw", 32'(rdat[7]), 32'h1);
    apb(1'b1, asp_pkg::ICR_OFF, 32'h80);
    apb(1'b0, asp_pkg::RIS_OFF, 32'h0);
    chk("framing cleared", 32'(rdat[7]), 32'h0);
    apb(1'b1, asp_pkg::IM_OFF, 32'h40);
    repeat (2) @(posedge pclk);
    chk("irq on", 32'(irq), 32'h1);
    apb(1'b0, asp_pkg::MIS_OFF, 32'h0);
    chk("masked", rdat & 32'h7f0, 32'h40);
    apb(1'b0, asp_pkg::DATA_OFF, 32'h0);
    chk("framing char", rdat & 32'hfff, 32'h181);
    apb(1'b0, asp_pkg::DATA_OFF, 32'h0);
    chk("clean char", rdat & 32'hfff, 32'h096);
    repeat (2) @(posedge pclk);
    apb(1'b0, asp_pkg::RIS_OFF, 32'h0);
    chk("timeout gone", 32'(rdat[6]), 32'h0);
    // Infrared first without loopback, so the idle-high line is not echoed
    apb(1'b1, asp_pkg::CTL_OFF, 32'h303);
    apb(1'b1, asp_pkg::CTL_OFF, 32'h383);
    apb(1'b1, asp_pkg::DATA_OFF, 32'hfe);
    pulse(hi, lo);
    chk("ir pulse", 32'(hi), 32'h3);
    chk("ir gap", 32'(lo), 32'hd);
    // Transmit ends before anything listens; turnaround gap scaled down
    repeat (200) @(posedge pclk);
    apb(1'b0, asp_pkg::FLAG_OFF, 32'h0);
    chk("ir echo ignored", rdat & 32'h18, 32'h10);
    // Port off, FIFOs off: one holding entry, a second write is dropped
    apb(1'b1, asp_pkg::CTL_OFF, 32'h300);
    apb(1'b1, asp_pkg::LCRH_OFF, 32'h60);
    apb(1'b1, asp_pkg::DATA_OFF, 32'h11);
    apb(1'b1, asp_pkg::DATA_OFF, 32'h22);
    apb(1'b0, asp_pkg::FLAG_OFF, 32'h0);
    chk("holding full", rdat & 32'ha0, 32'h20);
    wrap_up();
  end
endmodule
